// [src/adc_cycle_pkg.sv]
// Shared constants and types for the converter cycle sequencer and its host.
// Assumes one 20 MHz system clock drives both ends.
package adc_cycle_pkg;
  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned POR_TIME_US     = 1000;
  localparam int unsigned POR_CYCLES      = POR_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned CONV_TIME_US    = 146_700;
  localparam int unsigned CONV_CYCLES     = CONV_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned OSC_LOSS_US     = 400;
  localparam int unsigned OSC_LOSS_CYCLES = OSC_LOSS_US * (CLK_HZ / 1_000_000);
  localparam int unsigned ISCK_FREQ_HZ    = 17_500;
  localparam int unsigned ISCK_HALF_CYCLES = CLK_HZ / (2 * ISCK_FREQ_HZ);
  localparam int unsigned ESCK_LOW_NS     = 250;
  localparam int unsigned ESCK_HALF_CYCLES =
    (ESCK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NOTCH_DIV       = 2560;
  localparam int unsigned EXT_SCK_DIV     = 8;
  localparam int unsigned STAT_SETTLE_CYCLES = 2;
  // ==========================================================================
  // Data layout
  localparam int unsigned RESULT_BITS = 19;
  localparam int unsigned CHAN_BITS   = 5;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam logic [18:0] RESULT_OVER  = 19'h20000;
  localparam logic [18:0] RESULT_UNDER = 19'h3ffff;
  localparam logic [4:0]  CHAN_RESET   = 5'h00;
  // ==========================================================================
  // State encodings
  typedef enum logic [1:0] {
    ST_CONVERT = 2'b00,
    ST_SLEEP   = 2'b01,
    ST_OUTPUT  = 2'b10
  } dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE   = 3'b000,
    H_SETTLE = 3'b001,
    H_POLL   = 3'b010,
    H_XFER   = 3'b011,
    H_DONE   = 3'b100
  } host_state_t;
endpackage : adc_cycle_pkg

// [src/adc_link.sv]
// Four-wire serial link between the converter end and the host end.
// Assumes the clock pin has a weak pull-up only while the converter enables it.
`timescale 1ns/100ps
interface adc_link;
  logic cs_n;          // Select, active low, host driven
  logic sck_host_out;  // Host drive value for the clock pin
  logic sck_host_oe;   // Host drives the clock pin
  logic sck_dev_out;   // Converter drive value for the clock pin
  logic sck_dev_oe;    // Converter drives the clock pin
  logic sck_pullup_en; // Converter weak pull-up enable
  logic sck;           // Resolved clock pin level
  logic serial_in;     // Host to converter data
  logic serial_out;    // Converter to host data
  logic serial_out_oe; // Converter output enabled

  // ==========================================================================
  // Pin resolution; an undriven pin without pull-up is taken as low
  assign sck = sck_dev_oe ? sck_dev_out :
               (sck_host_oe ? sck_host_out : sck_pullup_en);

  modport dev  (input cs_n, sck, serial_in,
                output sck_dev_out, sck_dev_oe, sck_pullup_en, serial_out, serial_out_oe);
  modport host (input sck, serial_out, serial_out_oe,
                output cs_n, sck_host_out, sck_host_oe, serial_in);
endinterface : adc_link

// [src/word_fifo.sv]
// Synchronous FIFO with valid/ready on both sides.
// Assumes a single clock; depth is a power of two.
`timescale 1ns/100ps
module word_fifo #(
  parameter int unsigned WIDTH = 19,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             sys_clk_in,  // System clock
  input  wire logic             reset_n_in,  // Async reset, active low
  input  wire logic             in_valid_in, // Write request
  output logic                  in_ready_out, // Not full
  input  wire logic [WIDTH-1:0] in_data_in,  // Write word
  output logic                  out_valid_out, // Not empty
  input  wire logic             out_ready_in, // Reader takes word
  output logic      [WIDTH-1:0] out_data_out // Head word
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;
  logic             push;
  logic             pop;

  // ==========================================================================
  // Flags; full when pointers differ only in the wrap bit
  assign in_ready_out  = (wr_ptr_r ^ rd_ptr_r) != {1'b1, {AW{1'b0}}};
  assign out_valid_out = wr_ptr_r != rd_ptr_r;
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign out_data_out  = mem[rd_ptr_r[AW-1:0]];

  // Storage has no reset; only words behind the pointers are ever read
  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  // Pointers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)  rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end
endmodule : word_fifo

// [src/adc_cycle_dev.sv]
// Converter end: conversion/sleep/output sequencer and serial port.
// Assumes the host end keeps its own side of the link; analog result arrives
// on sample_in with range flags, sampled at the end of each conversion.
// Summary of operation
// R01 - Cycle convert, sleep, output, then convert again
// R02 - Sleep after conversion while select high
// R03 - Result held unchanged during sleep
// R04 - Select low wakes into data output state
// R05 - Select high before first rise: back to sleep
// R06 - Select high after first rise: abort, convert
// R07 - Channel bits shifted in, applied immediately
// R08 - Output changes on falling, host captures rising
// R09 - Output ends after nineteen bits, then convert
// R10 - Extra clocks beyond result read as high
// R11 - Data output enabled only while select low
// R12 - Status shown on data out before output
// R13 - Clock direction latched at power-up or select fall
// R14 - External clock on notch pin replaces oscillator
// R15 - Host keeps data input at valid level
// R16 - Modes come from pin timing, no registers
// R17 - Distinct overrange and underrange result codes
// R18 - Power-on reset hold, then normal conversion
// R19 - Data input sampled only on output rises
// R20 - Internal clock pulses only during data output
`timescale 1ns/100ps
module adc_cycle_dev #(
  parameter int unsigned POR_CYC        = adc_cycle_pkg::POR_CYCLES,
  parameter int unsigned CONV_CYC       = adc_cycle_pkg::CONV_CYCLES,
  parameter int unsigned OSC_LOSS_CYC   = adc_cycle_pkg::OSC_LOSS_CYCLES,
  parameter int unsigned EXT_CONV_EDGES = adc_cycle_pkg::NOTCH_DIV
) (
  input  wire logic        sys_clk_in,          // System clock, 20 MHz
  input  wire logic        reset_n_in,          // Async reset, active low
  adc_link.dev             link,                // Serial link
  input  wire logic        notch_clock_pin_in,  // Low or external oscillator
  input  wire logic [16:0] sample_in,           // Offset-binary conversion value
  input  wire logic        over_in,             // Input above full scale
  input  wire logic        under_in,            // Input below full scale
  output logic      [4:0]  channel_out,         // Channel for next conversion
  output logic             conv_done_out,       // One-cycle pulse at result load
  output logic      [1:0]  state_out,           // Current cycle state
  output logic             ext_osc_out,         // External oscillator in use
  output logic             int_sck_out          // Internal clock mode latched
);
  // ==========================================================================
  // Declarations
  adc_cycle_pkg::dev_state_t state_r;
  logic        cs_prev_r, sck_prev_r, notch_prev_r;
  logic        por_busy_r;
  logic [31:0] por_cnt_r, conv_cnt_r, idle_cnt_r, isck_cnt_r;
  logic        int_mode_r, ext_osc_r, isck_r, done_r;
  logic [1:0]  div_cnt_r;
  logic [5:0]  rise_cnt_r;
  logic [18:0] shreg_r;
  logic [4:0]  chan_shift_r, channel_r;
  logic        serial_out_r;
  logic        cs_fall, sck_rise, sck_fall, notch_rise, por_end;
  logic        base_tick, conv_end, isck_active, isck_half;
  logic [18:0] result;

  // ==========================================================================
  // Edge detection on link pins; inputs are synchronous to the clock
  assign cs_fall    = cs_prev_r & ~link.cs_n;
  assign sck_rise   = ~sck_prev_r & link.sck;
  assign sck_fall   = sck_prev_r & ~link.sck;
  assign notch_rise = ~notch_prev_r & notch_clock_pin_in;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cs_prev_r    <= 1'b1;
      sck_prev_r   <= 1'b0;
      notch_prev_r <= 1'b0;
    end else begin
      cs_prev_r    <= link.cs_n;
      sck_prev_r   <= link.sck;
      notch_prev_r <= notch_clock_pin_in;
    end
  end

  // ==========================================================================
  // Power-on hold; cycle state, conversion timer and clock direction stay at reset until it expires
  assign por_end = por_busy_r & (por_cnt_r == POR_CYC - 1);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      por_busy_r <= 1'b1;
      por_cnt_r  <= '0;
    end else if (por_busy_r) begin
      por_cnt_r <= por_cnt_r + 32'h1;                        // [R18]
      if (por_end) por_busy_r <= 1'b0;                       // [R18]
    end
  end

  // Clock direction: high level means internal mode, with pull-up on.
  // Taken from the pin itself, so no configuration state is needed.
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_mode_r <= 1'b0;
    end else if (por_end || (cs_fall && !por_busy_r)) begin
      int_mode_r <= link.sck;                                // [R13] [R16]
    end
  end

  // Oscillator source: any rise on the notch pin selects it; a quiet pin for
  // longer than the slowest legal period falls back to the internal one
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ext_osc_r  <= 1'b0;
      idle_cnt_r <= '0;
    end else if (notch_rise) begin
      ext_osc_r  <= 1'b1;                                    // [R14]
      idle_cnt_r <= '0;
    end else if (idle_cnt_r == OSC_LOSS_CYC - 1) begin
      ext_osc_r  <= 1'b0;                                    // [R14]
    end else begin
      idle_cnt_r <= idle_cnt_r + 32'h1;
    end
  end

  // ==========================================================================
  // Conversion timer counts oscillator ticks of whichever source is active
  assign base_tick = ext_osc_r ? notch_rise : 1'b1;          // [R14]
  assign conv_end  = (state_r == adc_cycle_pkg::ST_CONVERT) & ~por_busy_r & base_tick &
                     (conv_cnt_r >= (ext_osc_r ? EXT_CONV_EDGES : CONV_CYC) - 1);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      conv_cnt_r <= '0;
    end else if (state_r != adc_cycle_pkg::ST_CONVERT || conv_end) begin
      conv_cnt_r <= '0;
    end else if (!por_busy_r && base_tick) begin
      conv_cnt_r <= conv_cnt_r + 32'h1;
    end
  end

  // Range flags override the value so they cannot be mistaken for clipping
  assign result = over_in  ? adc_cycle_pkg::RESULT_OVER :    // [R17]
                  under_in ? adc_cycle_pkg::RESULT_UNDER :   // [R17]
                  {2'b00, sample_in};

  // ==========================================================================
  // Cycle state machine
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= adc_cycle_pkg::ST_CONVERT;
    end else begin
      unique case (state_r)
        adc_cycle_pkg::ST_CONVERT: begin
          if (conv_end) state_r <= adc_cycle_pkg::ST_SLEEP;  // [R01] [R02]
        end
        adc_cycle_pkg::ST_SLEEP: begin
          if (!link.cs_n) state_r <= adc_cycle_pkg::ST_OUTPUT; // [R04]
        end
        adc_cycle_pkg::ST_OUTPUT: begin
          if (link.cs_n) begin
            state_r <= (rise_cnt_r == 6'h00) ? adc_cycle_pkg::ST_SLEEP     // [R05]
                                             : adc_cycle_pkg::ST_CONVERT;  // [R06]
          end else if (sck_fall && rise_cnt_r == 6'(adc_cycle_pkg::RESULT_BITS)) begin
            state_r <= adc_cycle_pkg::ST_CONVERT;            // [R09] [R01]
          end
        end
        default: state_r <= adc_cycle_pkg::ST_CONVERT;
      endcase
    end
  end

  // Rising edges seen in this output state; saturates for long transfers
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rise_cnt_r <= '0;
    end else if (state_r != adc_cycle_pkg::ST_OUTPUT) begin
      rise_cnt_r <= '0;
    end else if (sck_rise && rise_cnt_r != 6'h3f) begin
      rise_cnt_r <= rise_cnt_r + 6'h01;
    end
  end

  // Result shift register: loaded only at conversion end, shifted only after
  // a rise, so a select pulse with no clock leaves it intact
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      shreg_r <= '0;
      done_r  <= 1'b0;
    end else begin
      done_r <= conv_end;
      if (conv_end) begin
        shreg_r <= result;
      end else if (state_r == adc_cycle_pkg::ST_OUTPUT && sck_fall &&
                   rise_cnt_r != 6'h00) begin
        shreg_r <= {shreg_r[17:0], 1'b1};                    // [R08] [R10] [R03]
      end
    end
  end

  // Channel bits: sampled on rises of the output state only
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      chan_shift_r <= adc_cycle_pkg::CHAN_RESET;
      channel_r    <= adc_cycle_pkg::CHAN_RESET;
    end else if (state_r == adc_cycle_pkg::ST_OUTPUT && sck_rise) begin
      chan_shift_r <= {chan_shift_r[3:0], link.serial_in};   // [R19]
      if (rise_cnt_r == 6'(adc_cycle_pkg::CHAN_BITS - 1)) begin
        channel_r <= {chan_shift_r[3:0], link.serial_in};    // [R07]
      end
    end
  end

  // ==========================================================================
  // Data out: status while converting or asleep, result bits while output
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      serial_out_r <= 1'b1;
    end else begin
      unique case (state_r)
        adc_cycle_pkg::ST_CONVERT: serial_out_r <= 1'b1;     // [R12] [R10]
        adc_cycle_pkg::ST_SLEEP:   serial_out_r <= 1'b0;     // [R12]
        adc_cycle_pkg::ST_OUTPUT:  serial_out_r <= shreg_r[18]; // [R08]
        default:                   serial_out_r <= 1'b1;
      endcase
    end
  end

  // ==========================================================================
  // Internal clock: oscillator/2*f or notch clock/8, only in output state
  assign isck_active = (state_r == adc_cycle_pkg::ST_OUTPUT) & int_mode_r & ~link.cs_n;
  assign isck_half   = ext_osc_r ? (notch_rise && div_cnt_r == 2'(adc_cycle_pkg::EXT_SCK_DIV/2 - 1))
                                 : (isck_cnt_r == adc_cycle_pkg::ISCK_HALF_CYCLES - 1);

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      isck_r     <= 1'b0;
      isck_cnt_r <= '0;
      div_cnt_r  <= '0;
    end else if (!isck_active) begin
      isck_r     <= 1'b0;                                    // [R20]
      isck_cnt_r <= '0;
      div_cnt_r  <= '0;
    end else begin
      isck_cnt_r <= isck_half ? 32'h0 : isck_cnt_r + 32'h1;
      if (notch_rise) div_cnt_r <= div_cnt_r + 2'h1;
      if (isck_half) isck_r <= ~isck_r;                      // [R20] [R14]
    end
  end

  // ==========================================================================
  // Outputs; clock pin left free at select fall
  assign link.sck_dev_out   = isck_r;
  assign link.sck_dev_oe    = int_mode_r & ~link.cs_n & ~cs_prev_r; // [R13]
  assign link.sck_pullup_en = int_mode_r;                    // [R13]
  assign link.serial_out    = serial_out_r;
  assign link.serial_out_oe = ~link.cs_n;                    // [R11]
  assign channel_out        = channel_r;
  assign conv_done_out      = done_r;
  assign state_out          = state_r;
  assign ext_osc_out        = ext_osc_r;
  assign int_sck_out        = int_mode_r;
endmodule : adc_cycle_dev

// [src/adc_cycle_host.sv]
// Host end: polls status in external clock mode, reads one result per cycle into a word FIFO.
// Assumes the converter end on the other side of the link.
`timescale 1ns/100ps
module adc_cycle_host (
  input  wire logic        sys_clk_in,       // System clock, 20 MHz
  input  wire logic        reset_n_in,       // Async reset, active low
  adc_link.host            link,             // Serial link
  input  wire logic        enable_in,        // Keep reading results
  input  wire logic        ext_sck_mode_in,  // 1: host makes the clock
  input  wire logic [4:0]  channel_in,       // Channel code to send
  output logic      [18:0] word_data_out,    // Result word at FIFO head
  output logic             word_valid_out,   // FIFO not empty
  input  wire logic        word_ready_in,    // Consumer takes word
  output logic             busy_out          // Transfer in progress
);
  // ==========================================================================
  // Declarations
  adc_cycle_pkg::host_state_t state_r;
  logic        cs_n_r, sck_r, ext_r, sck_prev_r, push_r;
  logic [31:0] cnt_r;
  logic [5:0]  rise_cnt_r;
  logic [4:0]  tx_r;
  logic [18:0] rx_r;
  logic        fifo_ready, half_tick, rise_ev, fall_ev;

  // ==========================================================================
  // Clock events: own timer in external mode, line edges in internal mode
  assign half_tick = (state_r == adc_cycle_pkg::H_XFER) & ext_r &
                     (cnt_r == adc_cycle_pkg::ESCK_HALF_CYCLES - 1);
  assign rise_ev   = (state_r == adc_cycle_pkg::H_XFER) &
                     (ext_r ? (half_tick & ~sck_r) : (~sck_prev_r & link.sck));
  assign fall_ev   = (state_r == adc_cycle_pkg::H_XFER) &
                     (ext_r ? (half_tick & sck_r) : (sck_prev_r & ~link.sck));

  // Sequencer; a new read starts only with FIFO room, so a stalled consumer
  // holds off the link instead of losing words
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r    <= adc_cycle_pkg::H_IDLE;
      cs_n_r     <= 1'b1;
      ext_r      <= 1'b1;
      cnt_r      <= '0;
      rise_cnt_r <= '0;
      push_r     <= 1'b0;
    end else begin
      push_r <= 1'b0;
      unique case (state_r)
        adc_cycle_pkg::H_IDLE: begin
          if (enable_in && fifo_ready) begin
            cs_n_r     <= 1'b0;                              // [R04]
            ext_r      <= ext_sck_mode_in;
            cnt_r      <= '0;
            rise_cnt_r <= '0;
            state_r    <= adc_cycle_pkg::H_SETTLE;
          end
        end
        adc_cycle_pkg::H_SETTLE: begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r == adc_cycle_pkg::STAT_SETTLE_CYCLES - 1) begin
            cnt_r   <= '0;
            state_r <= ext_r ? adc_cycle_pkg::H_POLL : adc_cycle_pkg::H_XFER;
          end
        end
        adc_cycle_pkg::H_POLL: begin
          if (link.serial_out_oe && !link.serial_out) state_r <= adc_cycle_pkg::H_XFER;
        end
        adc_cycle_pkg::H_XFER: begin
          if (ext_r) cnt_r <= half_tick ? 32'h0 : cnt_r + 32'h1;
          if (rise_ev) rise_cnt_r <= rise_cnt_r + 6'h01;
          if (fall_ev && rise_cnt_r == 6'(adc_cycle_pkg::RESULT_BITS)) begin
            cs_n_r  <= 1'b1;
            push_r  <= 1'b1;
            state_r <= adc_cycle_pkg::H_DONE;
          end
        end
        adc_cycle_pkg::H_DONE: state_r <= adc_cycle_pkg::H_IDLE;
        default:               state_r <= adc_cycle_pkg::H_IDLE;
      endcase
    end
  end

  // Clock drive, capture on rise, next channel bit on fall
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sck_r      <= 1'b0;
      sck_prev_r <= 1'b0;
      tx_r       <= '0;
      rx_r       <= '0;
    end else begin
      sck_prev_r <= link.sck;
      if (state_r == adc_cycle_pkg::H_IDLE) begin
        sck_r <= 1'b0;
        if (enable_in && fifo_ready) tx_r <= channel_in;
      end
      if (half_tick) sck_r <= ~sck_r;
      if (rise_ev) rx_r <= {rx_r[17:0], link.serial_out};    // [R08]
      if (fall_ev) tx_r <= {tx_r[3:0], 1'b0};                // [R07]
    end
  end

  // ==========================================================================
  // Link outputs; internal mode holds the pin high while deselected and in the first settle cycle
  assign link.cs_n         = cs_n_r;
  assign link.sck_host_out = ext_r ? sck_r : 1'b1;           // [R13]
  assign link.sck_host_oe  = ext_r | cs_n_r |                // [R13]
                             (state_r == adc_cycle_pkg::H_SETTLE && cnt_r == 32'h0);
  assign link.serial_in    = tx_r[4];                        // [R15]
  assign busy_out          = state_r != adc_cycle_pkg::H_IDLE;

  word_fifo #(
    .WIDTH (adc_cycle_pkg::RESULT_BITS),
    .DEPTH (adc_cycle_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_in    (sys_clk_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (push_r),
    .in_ready_out  (fifo_ready),
    .in_data_in    (rx_r),
    .out_valid_out (word_valid_out),
    .out_ready_in  (word_ready_in),
    .out_data_out  (word_data_out)
  );
endmodule : adc_cycle_host

// [tb/adc_link_checker.sv]
// Link checker: timing relations on the serial link between the two ends.
// Assumes plain copies of the link signals, sampled on the system clock.
`timescale 1ns/100ps
module adc_link_checker (
  input wire logic sys_clk_in,    // System clock
  input wire logic reset_n_in,    // Async reset, active low
  input wire logic cs_n,          // Select
  input wire logic sck,           // Resolved clock pin
  input wire logic serial_in,     // Host data
  input wire logic serial_out,    // Converter data
  input wire logic serial_out_oe, // Data enable
  input wire logic sck_dev_oe,    // Converter clock drive
  input wire logic sck_pullup_en  // Pull-up enable
);
  logic [5:0] rises_r; // Clock rises within this frame
  // ==========================================================================
  // Rise counter; cleared while deselected so an aborted frame cannot carry on
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) rises_r <= 6'h00;
    else if (cs_n) rises_r <= 6'h00;
    else if ($rose(sck) && !$fell(cs_n)) rises_r <= rises_r + 6'h01;
  end
  // ==========================================================================
  // Link relations
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence frame_end_s; $rose(cs_n) && rises_r == 6'h13; endsequence
  sequence rewake_s; $fell(cs_n); endsequence
  oe_follows_cs_a: assert property (serial_out_oe == !cs_n)
    else $error("data enable differs from select");
  out_hold_rise_a: assert property (!cs_n && !$fell(cs_n) && $rose(sck) |=>
    $stable(serial_out) [*3])
    else $error("data changed after a rising clock");
  dev_drive_sel_a: assert property (sck_dev_oe |-> !cs_n && sck_pullup_en)
    else $error("converter drives clock outside a frame");
  ext_clk_idle_a: assert property (cs_n && !sck_pullup_en |-> !sck)
    else $error("host clock not idle low");
  frame_len_a: assert property ($rose(cs_n) |-> rises_r == 6'h13)
    else $error("frame did not hold nineteen rises");
  in_hold_high_a: assert property (!cs_n && sck && $past(sck && !cs_n) |->
    $stable(serial_in))
    else $error("data input moved while clock high");
  wake_no_clk_a: assert property ($fell(cs_n) |=> !sck [*2])
    else $error("clock rose too soon after select");
  busy_after_frame_a: assert property (frame_end_s ##[1:8] rewake_s |-> ##[1:3] serial_out)
    else $error("busy status missing after frame");
endmodule : adc_link_checker

// [tb/testbench.sv]
// Testbench: both link ends joined; result notes checked against the FIFO.
// Assumes shortened counts, host-made clock then converter-made clock at the end, notch pin toggled late in run.
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t got %h expected %h", $time, a, b); end end
module testbench;
  logic        sys_clk_in = 1'b0;         // Clock, 50 ns
  logic        reset_n_in = 1'b0;         // Reset
  logic        notch_clock_pin_in = 1'b0; // Notch pin
  logic        toggle_en = 1'b0;          // Notch oscillator on
  logic [16:0] sample_in = 17'h00a5c;     // Conversion value
  logic        over_in = 1'b0;            // Above range
  logic        under_in = 1'b0;           // Below range
  logic [4:0]  channel_in = 5'h0a;        // Channel to send
  logic [4:0]  chan_sent;                 // Channel of this frame
  logic        word_ready_in = 1'b0;      // Consumer ready
  logic        ext_sck_mode_in = 1'b1;    // Host clock mode
  logic [4:0]  channel_out;
  logic [1:0]  state_out;
  logic [18:0] word_data_out, exp_w;
  logic        conv_done_out, ext_osc_out, int_sck_out, word_valid_out, busy_out, cs_q;
  logic [18:0] notes[$];                  // Expected words
  int          seed = 40331, bad_count = 0, num_checks = 0, dones = 0, r;
  adc_link adc_link_i ();
  adc_cycle_dev #(.POR_CYC(20), .CONV_CYC(200), .OSC_LOSS_CYC(50), .EXT_CONV_EDGES(16))
    adc_cycle_dev_i (.sys_clk_in, .reset_n_in, .link(adc_link_i), .notch_clock_pin_in,
    .sample_in, .over_in, .under_in, .channel_out, .conv_done_out, .state_out,
    .ext_osc_out, .int_sck_out);
  adc_cycle_host adc_cycle_host_i (.sys_clk_in, .reset_n_in, .link(adc_link_i),
    .enable_in(1'b1), .ext_sck_mode_in, .channel_in, .word_data_out,
    .word_valid_out, .word_ready_in, .busy_out);
  adc_link_checker adc_link_checker_i (.sys_clk_in, .reset_n_in, .cs_n(adc_link_i.cs_n),
    .sck(adc_link_i.sck), .serial_in(adc_link_i.serial_in),
    .serial_out(adc_link_i.serial_out), .serial_out_oe(adc_link_i.serial_out_oe),
    .sck_dev_oe(adc_link_i.sck_dev_oe), .sck_pullup_en(adc_link_i.sck_pullup_en));
  // ==========================================================================
  // Clock and closing
  initial forever #25 sys_clk_in = ~sys_clk_in;
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // ==========================================================================
  // Driver: note each loaded result, then offer fresh input for the next one
  always @(posedge sys_clk_in) begin
    if (reset_n_in && conv_done_out === 1'b1) begin
      dones++;
      notes.push_back(over_in ? adc_cycle_pkg::RESULT_OVER : (under_in ?
        adc_cycle_pkg::RESULT_UNDER : {2'h0, sample_in}));
      r = $random(seed);
      over_in <= r[2:0] == 3'h0;
      under_in <= r[2:0] == 3'h1;
      sample_in <= r[19:3];
    end
    if (toggle_en) notch_clock_pin_in <= ~notch_clock_pin_in;
  end
  // ==========================================================================
  // Monitor: channel held per frame, words taken against the oldest note
  always @(posedge sys_clk_in) begin
    cs_q <= adc_link_i.cs_n;
    if (cs_q === 1'b1 && adc_link_i.cs_n === 1'b0) chan_sent <= channel_in;
    if (cs_q === 1'b0 && adc_link_i.cs_n === 1'b1) begin
      `CHK(channel_out, chan_sent)
      channel_in <= 5'($random(seed));
    end
    if (word_valid_out === 1'b1 && word_ready_in === 1'b1) begin
      `CHK(notes.size() > 0, 1'b1)
      exp_w = notes.pop_front();
      `CHK(word_data_out, exp_w)
    end
  end
  // ==========================================================================
  // Main sequence: fill FIFO until host refuses, random drain with notch clock from its midpoint, then converter clock
  initial begin
    repeat (12) @(posedge sys_clk_in);
    reset_n_in <= 1'b1;
    repeat (9000) @(posedge sys_clk_in);
    `CHK(dones, 17)
    `CHK(state_out, 2'h1)
    `CHK(busy_out, 1'b0)
    `CHK(int_sck_out, 1'b0)
    for (int i = 0; i < 8000; i++) begin
      @(posedge sys_clk_in);
      word_ready_in <= 1'($random(seed));
      if (i == 4000) toggle_en <= 1'b1;
    end
    `CHK(ext_osc_out, 1'b1)
    word_ready_in <= 1'b1;
    ext_sck_mode_in <= 1'b0;
    repeat (2000) @(posedge sys_clk_in);
    `CHK(notes.size() < 2, 1'b1)
    `CHK(int_sck_out, 1'b1)
    complete_run();
  end
  // Watchdog: run should end near 19000 cycles
  initial begin
    repeat (30000) @(posedge sys_clk_in);
    bad_count++;
    complete_run();
  end
endmodule : testbench
